/* File: rtl/left_effects_coef_regs.sv */
// Purpose: Left-channel effects and de-emphasis coefficient byte bank with
//          read/write access and assembled signed coefficient outputs.
// Assumes: Plain register port; read data one cycle after the read strobe.
// Notes:   Unmapped reads return zero; unmapped writes are ignored.
//          Two coefficient halves live in neighbouring banks and arrive
//          on the external byte inputs, so all five coefficients leave
//          this bank whole.
// Contract
// - Byte pair forms signed 16-bit coefficient.
// - Bytes are eight bits, writable, readable.
// - Feedback one low byte resets 0x83.
// - Feedback two resets 0x84 and 0xEE.
// - Feedback four resets 0x7D and 0x83.
// - Feedback five resets 0x84 and 0xEE.
// - De-emphasis zero high byte resets 0x39.
//
// The plain strobed port was left to the implementer.
`timescale 1ns/1ns
module left_effects_coef_regs (
  input wire logic clk, // System clock, 100 MHz.
  input wire logic nrst, // Asynchronous reset, active low.
  input wire coef_regs_pkg::reg_req_type req, // Register port request.
  output logic [coef_regs_pkg::DATA_W-1:0] rd_data, // Read data, next cycle.
  input wire coef_regs_pkg::ext_bytes_type ext_bytes, // Neighbour bytes.
  output coef_regs_pkg::coef_set_type coefs // Coefficients to datapath.
);
  import coef_regs_pkg::*;

  // Register map of this bank, one byte per offset:
  //   0x0E  feedback one, lower byte; its upper byte lives elsewhere.
  //   0x0F  feedback two, upper byte.
  //   0x10  feedback two, lower byte.
  //   0x11  feedback four, upper byte.
  //   0x12  feedback four, lower byte.
  //   0x13  feedback five, upper byte.
  //   0x14  feedback five, lower byte.
  //   0x15  de-emphasis zero, upper byte; its lower byte lives elsewhere.
  // Every other offset is outside the bank: writes there are dropped and
  // reads there return zero, so neighbouring banks can share the port.
  // The offsets and defaults themselves live in the package.

  // Stored bytes, one slot per register, in slot order.
  logic [DATA_W-1:0] slot_q [NUM_REGS];
  // Per-slot write strobes after address decode.
  logic [NUM_REGS-1:0] slot_wr;
  // Address decode results for the write and the read strobe.
  logic wr_hit;
  logic [2:0] wr_slot;
  logic rd_hit;
  logic [2:0] rd_slot;
  // Read data register and its next value.
  logic [DATA_W-1:0] rd_data_reg;
  logic [DATA_W-1:0] rd_data_next;
  // Upper and lower byte of each coefficient before joining.
  logic [DATA_W-1:0] coef_one_hi;
  logic [DATA_W-1:0] coef_one_lo;
  logic [DATA_W-1:0] coef_two_hi;
  logic [DATA_W-1:0] coef_two_lo;
  logic [DATA_W-1:0] coef_four_hi;
  logic [DATA_W-1:0] coef_four_lo;
  logic [DATA_W-1:0] coef_five_hi;
  logic [DATA_W-1:0] coef_five_lo;
  logic [DATA_W-1:0] coef_zero_hi;
  logic [DATA_W-1:0] coef_zero_lo;
  // Coefficient set register and its next value.
  coef_set_type coefs_reg;
  coef_set_type coefs_next;

  // Returns the slot that answers an address, and whether any does.
  // Bit 3 is the hit flag and bits 2:0 the slot; a miss returns zero.
  // Offsets are compared whole; no address bit is ignored.
  function automatic logic [3:0] decode_slot(input logic [ADDR_W-1:0] a);
    logic [3:0] res;
    res = 4'h0;
    case (a)
      OFF_FB_ONE_LOW: begin
        res = {1'b1, 3'(IDX_FB_ONE_LOW)};
      end
      OFF_FB_TWO_HIGH: begin
        res = {1'b1, 3'(IDX_FB_TWO_HIGH)};
      end
      OFF_FB_TWO_LOW: begin
        res = {1'b1, 3'(IDX_FB_TWO_LOW)};
      end
      OFF_FB_FOUR_HIGH: begin
        res = {1'b1, 3'(IDX_FB_FOUR_HIGH)};
      end
      OFF_FB_FOUR_LOW: begin
        res = {1'b1, 3'(IDX_FB_FOUR_LOW)};
      end
      OFF_FB_FIVE_HIGH: begin
        res = {1'b1, 3'(IDX_FB_FIVE_HIGH)};
      end
      OFF_FB_FIVE_LOW: begin
        res = {1'b1, 3'(IDX_FB_FIVE_LOW)};
      end
      OFF_DEEMPH_ZERO_HIGH: begin
        res = {1'b1, 3'(IDX_DEEMPH_ZERO_HIGH)};
      end
      default: begin
        res = 4'h0;
      end
    endcase
    return res;
  endfunction

  // Joins an upper and a lower byte into one signed coefficient.
  // The upper byte carries the sign, so 0x80 0x00 is the most negative.
  // The result is handed on unchanged; no rounding or saturation.
  function automatic logic signed [COEF_W-1:0] join_coef(
    input logic [DATA_W-1:0] hi,
    input logic [DATA_W-1:0] lo
  );
    return $signed({hi, lo});
  endfunction

  // Address decode for the two strobes; both look at the same address.
  assign {wr_hit, wr_slot} = decode_slot(req.addr);
  assign {rd_hit, rd_slot} = decode_slot(req.addr);

  // Only a mapped write raises a strobe, and only for its own slot, so an
  // unmapped write leaves every byte as it was.
  // decoded write strobes
  always_comb begin
    slot_wr = '0;
    if (req.wr && wr_hit) begin
      slot_wr[wr_slot] = 1'b1;
    end
  end

  // Each byte below is one eight-bit store with its own fixed default.
  // All eight bits are writable and read back exactly as written.
  // The stores sit on the same clock as the port, so a write taken at an
  // edge is visible to a read taken at the very next edge.

  // Feedback one, lower byte.
  // feedback one low
  coef_byte_store #(
    .WIDTH(DATA_W),
    .RESET_VALUE(RST_FB_ONE_LOW)
  ) u_fb_one_low (
    .clk(clk),
    .nrst(nrst),
    .wr_en(slot_wr[IDX_FB_ONE_LOW]),
    .wr_data(req.wdata),
    .q(slot_q[IDX_FB_ONE_LOW])
  );

  // Feedback two, upper byte.
  // feedback two high
  coef_byte_store #(
    .WIDTH(DATA_W),
    .RESET_VALUE(RST_FB_TWO_HIGH)
  ) u_fb_two_high (
    .clk(clk),
    .nrst(nrst),
    .wr_en(slot_wr[IDX_FB_TWO_HIGH]),
    .wr_data(req.wdata),
    .q(slot_q[IDX_FB_TWO_HIGH])
  );

  // Feedback two, lower byte.
  // feedback two low
  coef_byte_store #(
    .WIDTH(DATA_W),
    .RESET_VALUE(RST_FB_TWO_LOW)
  ) u_fb_two_low (
    .clk(clk),
    .nrst(nrst),
    .wr_en(slot_wr[IDX_FB_TWO_LOW]),
    .wr_data(req.wdata),
    .q(slot_q[IDX_FB_TWO_LOW])
  );

  // Feedback four, upper byte.
  // feedback four high
  coef_byte_store #(
    .WIDTH(DATA_W),
    .RESET_VALUE(RST_FB_FOUR_HIGH)
  ) u_fb_four_high (
    .clk(clk),
    .nrst(nrst),
    .wr_en(slot_wr[IDX_FB_FOUR_HIGH]),
    .wr_data(req.wdata),
    .q(slot_q[IDX_FB_FOUR_HIGH])
  );

  // Feedback four, lower byte.
  // feedback four low
  coef_byte_store #(
    .WIDTH(DATA_W),
    .RESET_VALUE(RST_FB_FOUR_LOW)
  ) u_fb_four_low (
    .clk(clk),
    .nrst(nrst),
    .wr_en(slot_wr[IDX_FB_FOUR_LOW]),
    .wr_data(req.wdata),
    .q(slot_q[IDX_FB_FOUR_LOW])
  );

  // Feedback five, upper byte.
  // feedback five high
  coef_byte_store #(
    .WIDTH(DATA_W),
    .RESET_VALUE(RST_FB_FIVE_HIGH)
  ) u_fb_five_high (
    .clk(clk),
    .nrst(nrst),
    .wr_en(slot_wr[IDX_FB_FIVE_HIGH]),
    .wr_data(req.wdata),
    .q(slot_q[IDX_FB_FIVE_HIGH])
  );

  // Feedback five, lower byte.
  // feedback five low
  coef_byte_store #(
    .WIDTH(DATA_W),
    .RESET_VALUE(RST_FB_FIVE_LOW)
  ) u_fb_five_low (
    .clk(clk),
    .nrst(nrst),
    .wr_en(slot_wr[IDX_FB_FIVE_LOW]),
    .wr_data(req.wdata),
    .q(slot_q[IDX_FB_FIVE_LOW])
  );

  // De-emphasis zero, upper byte.
  // de-emphasis zero high
  coef_byte_store #(
    .WIDTH(DATA_W),
    .RESET_VALUE(RST_DEEMPH_ZERO_HIGH)
  ) u_deemph_zero_high (
    .clk(clk),
    .nrst(nrst),
    .wr_en(slot_wr[IDX_DEEMPH_ZERO_HIGH]),
    .wr_data(req.wdata),
    .q(slot_q[IDX_DEEMPH_ZERO_HIGH])
  );

  // Read path: the addressed byte for a mapped read, else zero, so the
  // read data sit at zero in every cycle that does not follow a read.
  // read back
  always_comb begin
    rd_data_next = UNMAPPED_READ;
    if (req.rd && rd_hit) begin
      rd_data_next = slot_q[rd_slot];
    end
  end

  // Read data register; a byte stands for exactly one cycle and reset
  // parks it at zero.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rd_data_reg <= UNMAPPED_READ;
    end else begin
      rd_data_reg <= rd_data_next;
    end
  end

  // Read data leave the bank straight from the register.
  assign rd_data = rd_data_reg;

  // Pairs the bytes of each coefficient. Two of them borrow one half from
  // the neighbouring banks through the external byte inputs.
  // The order inside each pair is fixed: upper byte high.
  assign coef_one_hi = ext_bytes.fb_one_high;
  assign coef_one_lo = slot_q[IDX_FB_ONE_LOW];
  assign coef_two_hi = slot_q[IDX_FB_TWO_HIGH];
  assign coef_two_lo = slot_q[IDX_FB_TWO_LOW];
  assign coef_four_hi = slot_q[IDX_FB_FOUR_HIGH];
  assign coef_four_lo = slot_q[IDX_FB_FOUR_LOW];
  assign coef_five_hi = slot_q[IDX_FB_FIVE_HIGH];
  assign coef_five_lo = slot_q[IDX_FB_FIVE_LOW];
  assign coef_zero_hi = slot_q[IDX_DEEMPH_ZERO_HIGH];
  assign coef_zero_lo = ext_bytes.deemph_zero_low;

  // The halves are joined upper byte high, lower byte low, and read as a
  // signed value. Partner bytes are not written atomically, so software
  // should rewrite a coefficient only while the filter is idle.
  // A write therefore reaches the datapath one edge after it is taken.
  // signed byte join
  always_comb begin
    coefs_next.fx_feedback_coef_one = join_coef(coef_one_hi, coef_one_lo);
    coefs_next.fx_feedback_coef_two = join_coef(coef_two_hi, coef_two_lo);
    coefs_next.fx_feedback_coef_four = join_coef(coef_four_hi, coef_four_lo);
    coefs_next.fx_feedback_coef_five = join_coef(coef_five_hi, coef_five_lo);
    coefs_next.deemph_forward_coef_zero =
      join_coef(coef_zero_hi, coef_zero_lo);
  end

  // Coefficient set register; the datapath sees a byte change one edge
  // after the byte itself changes, and sees zero while reset is held.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      coefs_reg <= '0;
    end else begin
      coefs_reg <= coefs_next;
    end
  end

  assign coefs = coefs_reg;

endmodule

/* File: rtl/coef_regs_pkg.sv */
// Purpose: Shared constants and carriers for the left-channel coefficient
//          byte bank.
// Assumes: Byte-wide register port with an 8-bit address.
// Notes:   Offsets are the byte addresses on the plain register port.
package coef_regs_pkg;

  // Widths of the register port and of one coefficient.
  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;
  localparam int COEF_W = 16;
  localparam int NUM_REGS = 8;

  // Register offsets on the register port.
  localparam logic [7:0] OFF_FB_ONE_LOW = 8'h0E;
  localparam logic [7:0] OFF_FB_TWO_HIGH = 8'h0F;
  localparam logic [7:0] OFF_FB_TWO_LOW = 8'h10;
  localparam logic [7:0] OFF_FB_FOUR_HIGH = 8'h11;
  localparam logic [7:0] OFF_FB_FOUR_LOW = 8'h12;
  localparam logic [7:0] OFF_FB_FIVE_HIGH = 8'h13;
  localparam logic [7:0] OFF_FB_FIVE_LOW = 8'h14;
  localparam logic [7:0] OFF_DEEMPH_ZERO_HIGH = 8'h15;

  // Values after reset.
  localparam logic [7:0] RST_FB_ONE_LOW = 8'h83;
  localparam logic [7:0] RST_FB_TWO_HIGH = 8'h84;
  localparam logic [7:0] RST_FB_TWO_LOW = 8'hEE;
  localparam logic [7:0] RST_FB_FOUR_HIGH = 8'h7D;
  localparam logic [7:0] RST_FB_FOUR_LOW = 8'h83;
  localparam logic [7:0] RST_FB_FIVE_HIGH = 8'h84;
  localparam logic [7:0] RST_FB_FIVE_LOW = 8'hEE;
  localparam logic [7:0] RST_DEEMPH_ZERO_HIGH = 8'h39;

  // Storage slot of each register inside the bank.
  localparam int IDX_FB_ONE_LOW = 0;
  localparam int IDX_FB_TWO_HIGH = 1;
  localparam int IDX_FB_TWO_LOW = 2;
  localparam int IDX_FB_FOUR_HIGH = 3;
  localparam int IDX_FB_FOUR_LOW = 4;
  localparam int IDX_FB_FIVE_HIGH = 5;
  localparam int IDX_FB_FIVE_LOW = 6;
  localparam int IDX_DEEMPH_ZERO_HIGH = 7;

  // Offset and reset value per slot, in slot order.
  localparam logic [7:0] SLOT_OFFSET [NUM_REGS] = '{
    OFF_FB_ONE_LOW, OFF_FB_TWO_HIGH, OFF_FB_TWO_LOW, OFF_FB_FOUR_HIGH,
    OFF_FB_FOUR_LOW, OFF_FB_FIVE_HIGH, OFF_FB_FIVE_LOW,
    OFF_DEEMPH_ZERO_HIGH};
  localparam logic [7:0] SLOT_RESET [NUM_REGS] = '{
    RST_FB_ONE_LOW, RST_FB_TWO_HIGH, RST_FB_TWO_LOW, RST_FB_FOUR_HIGH,
    RST_FB_FOUR_LOW, RST_FB_FIVE_HIGH, RST_FB_FIVE_LOW,
    RST_DEEMPH_ZERO_HIGH};

  // Value shown by a read of an unmapped address.
  localparam logic [7:0] UNMAPPED_READ = 8'h00;

  // One request on the register port.
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic wr;
    logic rd;
  } reg_req_type;

  // Assembled signed coefficients handed to the filter datapath.
  typedef struct packed {
    logic signed [COEF_W-1:0] fx_feedback_coef_one;
    logic signed [COEF_W-1:0] fx_feedback_coef_two;
    logic signed [COEF_W-1:0] fx_feedback_coef_four;
    logic signed [COEF_W-1:0] fx_feedback_coef_five;
    logic signed [COEF_W-1:0] deemph_forward_coef_zero;
  } coef_set_type;

  // Bytes of the same coefficients that live in neighbouring banks.
  typedef struct packed {
    logic [DATA_W-1:0] fb_one_high;
    logic [DATA_W-1:0] deemph_zero_low;
  } ext_bytes_type;

endpackage

/* File: rtl/coef_byte_store.sv */
// Purpose: One read/write coefficient byte with a fixed reset value.
// Assumes: Write enable is already qualified by address decode.
// Notes:   All eight bits are writable and read back unchanged.
`timescale 1ns/1ns
module coef_byte_store #(
  parameter int WIDTH = 8,
  parameter logic [WIDTH-1:0] RESET_VALUE = '0
) (
  input wire logic clk, // System clock.
  input wire logic nrst, // Asynchronous reset, active low.
  input wire logic wr_en, // Load the byte this cycle.
  input wire logic [WIDTH-1:0] wr_data, // Byte to store.
  output logic [WIDTH-1:0] q // Stored byte.
);

  logic [WIDTH-1:0] byte_reg;
  logic [WIDTH-1:0] byte_next;

  // Next value: take the write data when enabled, else hold.
  always_comb begin
    byte_next = byte_reg;
    if (wr_en) begin
      byte_next = wr_data;
    end
  end

  // Storage flop, loaded with its fixed default under reset.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      byte_reg <= RESET_VALUE;
    end else begin
      byte_reg <= byte_next;
    end
  end

  assign q = byte_reg;

endmodule

/* File: bench/coef_regs_properties.sv */
// Purpose: Port checker for the left coefficient byte bank.
// Assumes: One clock; reset is asynchronous and active low.
// Notes: Bound to every instance of the bank.
`timescale 1ns/1ns
module coef_regs_properties (
  input wire logic clk, // Clock.
  input wire logic nrst, // Reset, active low.
  input wire coef_regs_pkg::reg_req_type req, // Register request.
  input wire logic [coef_regs_pkg::DATA_W-1:0] rd_data, // Read data.
  input wire coef_regs_pkg::ext_bytes_type ext_bytes, // Neighbour bytes.
  input wire coef_regs_pkg::coef_set_type coefs // Coefficients.
);
  import coef_regs_pkg::*;
  // Every check runs on the rising edge outside reset.
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  a_wr_then_rd: assert property ((req.wr && req.addr == 8'h10) ##1
    (req.rd && req.addr == 8'h10) |=> rd_data == $past(req.wdata, 2))
    else $error("read after write lost data");
  a_idle_zero: assert property (!req.rd |=> rd_data == 8'h00)
    else $error("read data not zero when idle");
  a_unmapped_zero: assert property (req.rd &&
    (req.addr < 8'h0E || req.addr > 8'h15) |=> rd_data == 8'h00)
    else $error("unmapped read not zero");
  a_ext_high: assert property (nrst |=>
    coefs.fx_feedback_coef_one[15:8] == $past(ext_bytes.fb_one_high))
    else $error("coef one high byte wrong");
  a_ext_low: assert property (nrst |=>
    coefs.deemph_forward_coef_zero[7:0] == $past(ext_bytes.deemph_zero_low))
    else $error("deemph low byte wrong");
  a_wr_to_coef: assert property ((req.wr && req.addr == 8'h0F) ##1
    !(req.wr && req.addr == 8'h0F) |=>
    coefs.fx_feedback_coef_two[15:8] == $past(req.wdata, 2))
    else $error("coef two high byte not updated");
  a_rst_pairs: assert property ($rose(nrst) |=>
    coefs.fx_feedback_coef_two == 16'h84EE &&
    coefs.fx_feedback_coef_four == 16'h7D83 &&
    coefs.fx_feedback_coef_five == 16'h84EE)
    else $error("coefficient pair defaults wrong");
  a_rst_single: assert property ($rose(nrst) |=>
    coefs.fx_feedback_coef_one[7:0] == 8'h83 &&
    coefs.deemph_forward_coef_zero[15:8] == 8'h39)
    else $error("single byte defaults wrong");
  // Main scenarios reached.
  c_wr_rd: cover property (req.wr ##1 req.rd);
  c_unmapped: cover property (req.rd && req.addr > 8'h15);
  c_release: cover property ($rose(nrst));
endmodule
bind left_effects_coef_regs coef_regs_properties chk (.clk(clk),
  .nrst(nrst), .req(req), .rd_data(rd_data), .ext_bytes(ext_bytes),
  .coefs(coefs));

/* File: bench/left_effects_coef_regs_tb_top.sv */
// Purpose: Self-checking bench for the left coefficient byte bank.
// Assumes: Read data stand in the cycle after the read strobe.
// Notes: Offset 0x12 holds the feedback four low byte.
`timescale 1ns/1ns
module left_effects_coef_regs_tb_top;
  import coef_regs_pkg::*;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  reg_req_type req = '0;
  ext_bytes_type ext_bytes = '{8'hA5, 8'h5A};
  logic [7:0] rd_data;
  coef_set_type coefs;
  int n_errors = 0;
  int num_checks = 0;
  logic [7:0] dflt [8] = '{8'h83, 8'h84, 8'hEE, 8'h7D, 8'h83, 8'h84, 8'hEE,
    8'h39};
  // Free-running 100 MHz clock.
  always #5 clk = ~clk;
  left_effects_coef_regs dut (.clk(clk), .nrst(nrst), .req(req),
    .rd_data(rd_data), .ext_bytes(ext_bytes), .coefs(coefs));
  task report_and_stop;
    if (n_errors == 0 && num_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task chk(input string what, input logic [79:0] exp, got);
    num_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value %s exp %h got %h", what, exp, got);
    end
  endtask
  task wr(input logic [7:0] a, d);
    @(posedge clk) req <= '{a, d, 1'b1, 1'b0};
  endtask
  task rd(input logic [7:0] a, exp);
    @(posedge clk) req <= '{a, 8'h00, 1'b0, 1'b1};
    @(posedge clk) req <= '0;
    #1 chk("rd_data", {72'h0, exp}, {72'h0, rd_data});
  endtask
  task t_defaults;
    for (int i = 0; i < 8; i++) rd(SLOT_OFFSET[i], dflt[i]);
    chk("coefs", {ext_bytes.fb_one_high, 8'h83, 16'h84EE, 16'h7D83,
      16'h84EE, 8'h39, ext_bytes.deemph_zero_low}, coefs);
  endtask
  task t_rw;
    for (int i = 0; i < 8; i++) begin
      wr(SLOT_OFFSET[i], ~dflt[i]);
      rd(SLOT_OFFSET[i], ~dflt[i]);
    end
    chk("coefs", {8'hA5, 8'h7C, 16'h7B11, 16'h827C, 16'h7B11, 8'hC6,
      8'h5A}, coefs);
    wr(8'h0F, 8'h80);
    wr(8'h10, 8'h00);
    wr(8'h11, 8'h7F);
    wr(8'h12, 8'hFF);
    rd(8'h12, 8'hFF);
    chk("coef_two", 80'h8000, {64'h0, coefs.fx_feedback_coef_two});
    chk("coef_four", 80'h7FFF, {64'h0, coefs.fx_feedback_coef_four});
  endtask
  task t_unmapped;
    wr(8'h16, 8'h55);
    rd(8'h16, 8'h00);
    rd(8'h0D, 8'h00);
    rd(8'h0E, 8'h7C);
  endtask
  task t_ext;
    @(posedge clk) ext_bytes <= '{8'h80, 8'h01};
    repeat (2) @(posedge clk);
    #1 chk("coef_one", 80'h807C, {64'h0, coefs.fx_feedback_coef_one});
    chk("deemph", 80'hC601, {64'h0, coefs.deemph_forward_coef_zero});
  endtask
  // Main sequence, including a second reset in mid-run.
  initial begin
    repeat (10) @(posedge clk);
    nrst <= 1'b1;
    t_defaults;
    t_rw;
    t_unmapped;
    t_ext;
    @(posedge clk) nrst <= 1'b0;
    repeat (3) @(posedge clk);
    nrst <= 1'b1;
    t_defaults;
    report_and_stop;
  end
  // Watchdog far beyond the ninety or so cycles the tests need.
  initial begin
    #20000;
    n_errors++;
    report_and_stop;
  end
endmodule
